// file: hw/rio_pkg.sv
// shared constants and types for the remote io serial master and slave
package rio_pkg;
  // station addressing
  localparam int RIO_MAX_SLAVES = 4;
  localparam logic [3:0] RIO_MASTER_ADDR = 4'h0;
  localparam logic [3:0] RIO_SLV_ADDR_MIN = 4'h1;
  localparam logic [3:0] RIO_SLV_ADDR_MAX = 4'hf;
  // error total
  localparam logic [15:0] RIO_ERR_RST = 16'h0000;
  localparam logic [15:0] RIO_ERR_MAX = 16'hffff;
  localparam logic [15:0] RIO_ERR_ONE = 16'h0001;
  // retry limit, 0 means no retry
  localparam logic [1:0] RIO_RETRY_RST = 2'h0;
  localparam logic [1:0] RIO_RETRY_MAX = 2'h3;
  // answer timeout, longest wait rounds down to whole cycles
  localparam int RIO_CLK_NS = 8;
  localparam int RIO_RSP_TIMEOUT_NS = 200;
  localparam logic [7:0] RIO_RSP_TIMEOUT_CYC = 8'(RIO_RSP_TIMEOUT_NS / RIO_CLK_NS);
  localparam logic [7:0] RIO_TMO_LAST = 8'h01;
  // slave reset values
  localparam logic [7:0] RIO_OUT_RST = 8'h00;

  typedef logic [3:0] rio_addr_t;
  typedef logic [3:0] rio_type_t;
  typedef logic [7:0] rio_data_t;
  typedef enum logic [1:0] {RIO_CMD_INIT, RIO_CMD_READ, RIO_CMD_WRITE} rio_cmd_e;
  typedef enum logic [1:0] {RIO_ST_OK, RIO_ST_INIT_ERR, RIO_ST_NO_SLAVE, RIO_ST_TIMEOUT}
    rio_status_e;

  // a slave station must sit in 1..f, never on the master's own address
  function automatic logic rio_addr_ok(input rio_addr_t a);
    return (a >= RIO_SLV_ADDR_MIN) && (a <= RIO_SLV_ADDR_MAX);
  endfunction
endpackage

// file: hw/rio_link_if.sv
// word-level model of the remote io serial link between master and one slave
`timescale 1ns/10ps
`default_nettype none
interface rio_link_if (
  input wire logic ref_clk,
  input wire logic rst_b
);
  import rio_pkg::*;
  // request from master
  logic req_valid;
  rio_addr_t req_src;
  rio_addr_t req_dst;
  rio_cmd_e req_cmd;
  rio_data_t req_data;
  // answer from slave
  logic rsp_valid;
  rio_addr_t rsp_src;
  rio_addr_t rsp_dst;
  rio_status_e rsp_status;
  rio_data_t rsp_data;

  modport master (
    input ref_clk, rst_b,
    output req_valid, req_src, req_dst, req_cmd, req_data,
    input rsp_valid, rsp_src, rsp_dst, rsp_status, rsp_data
  );
  modport slave (
    input ref_clk, rst_b,
    input req_valid, req_src, req_dst, req_cmd, req_data,
    output rsp_valid, rsp_src, rsp_dst, rsp_status, rsp_data
  );
endinterface
`default_nettype wire

// file: hw/rio_slave.sv
// remote io slave end: init interlock, input read and output write
`timescale 1ns/10ps
`default_nettype none
module rio_slave (
  // link
  rio_link_if.slave link,
  // station setup
  input wire rio_pkg::rio_addr_t station_addr,
  input wire rio_pkg::rio_type_t unit_type,
  // io points
  input wire rio_pkg::rio_data_t in_pins,
  output rio_pkg::rio_data_t out_pins,
  // fault injection and state
  input wire logic drop_rsp,
  output logic initialized
);
  import rio_pkg::*;

  logic init_q;
  rio_addr_t addr_q;
  rio_data_t out_q;
  logic rsp_valid_q;
  rio_addr_t rsp_dst_q;
  rio_status_e rsp_status_q;
  rio_data_t rsp_data_q;
  logic hit_c;

  // frames from anyone but the master, or for another station, are ignored
  assign hit_c = link.req_valid && (link.req_src == RIO_MASTER_ADDR) &&
                 rio_addr_ok(addr_q) && (link.req_dst == addr_q);

  // station strap is followed every cycle, never caught by reset
  always_ff @(posedge link.ref_clk) begin
    addr_q <= station_addr;
  end

  // uninitialised after power-up until an init request arrives
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      init_q <= 1'b0;
    end else if (hit_c && link.req_cmd == RIO_CMD_INIT) begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      out_q <= RIO_OUT_RST;
    end else if (hit_c && init_q && link.req_cmd == RIO_CMD_WRITE) begin
      out_q <= link.req_data;
    end
  end

  // one answer per accepted request while drop_rsp is low, on the following cycle
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      rsp_valid_q <= 1'b0;
      rsp_dst_q <= RIO_MASTER_ADDR;
      rsp_status_q <= RIO_ST_OK;
      rsp_data_q <= RIO_OUT_RST;
    end else begin
      rsp_valid_q <= hit_c && !drop_rsp;
      if (hit_c) begin
        rsp_dst_q <= link.req_src;
        if (link.req_cmd == RIO_CMD_INIT) begin
          rsp_status_q <= RIO_ST_OK;
          rsp_data_q <= {4'h0, unit_type};
        end else if (!init_q) begin
          rsp_status_q <= RIO_ST_INIT_ERR;
          rsp_data_q <= RIO_OUT_RST;
        end else if (link.req_cmd == RIO_CMD_READ) begin
          rsp_status_q <= RIO_ST_OK;
          rsp_data_q <= in_pins;
        end else begin
          rsp_status_q <= RIO_ST_OK;
          rsp_data_q <= link.req_data;
        end
      end
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_src = addr_q;
  assign link.rsp_dst = rsp_dst_q;
  assign link.rsp_status = rsp_status_q;
  assign link.rsp_data = rsp_data_q;
  assign out_pins = out_q;
  assign initialized = init_q;
endmodule // rio_slave
`default_nettype wire

// file: hw/rio_master.sv
// remote io serial master: slave init, app requests, retry and error total
`timescale 1ns/10ps
`default_nettype none
module rio_master (
  // link
  rio_link_if.master link,
  // environment setup
  input wire logic env_set,
  input wire logic [1:0] env_retry,
  input wire rio_pkg::rio_addr_t slot_addr [rio_pkg::RIO_MAX_SLAVES],
  output logic env_busy,
  // attached slave information
  output logic [rio_pkg::RIO_MAX_SLAVES-1:0] slot_present,
  output rio_pkg::rio_type_t slot_type [rio_pkg::RIO_MAX_SLAVES],
  // application request
  input wire logic app_valid,
  output logic app_ready,
  input wire logic [1:0] app_slot,
  input wire rio_pkg::rio_cmd_e app_cmd,
  input wire rio_pkg::rio_data_t app_wdata,
  // application answer
  output logic app_rsp_valid,
  output rio_pkg::rio_status_e app_rsp_status,
  output rio_pkg::rio_data_t app_rsp_data,
  // error total
  input wire logic err_clr,
  output logic [15:0] err_total
);
  import rio_pkg::*;

  typedef enum logic [1:0] {RIO_IDLE, RIO_SEND, RIO_WAIT} rio_state_e;

  rio_state_e state_q;
  logic [1:0] slot_q;
  rio_addr_t dst_q;
  rio_cmd_e cmd_q;
  rio_data_t wdata_q;
  logic init_run_q;
  logic [1:0] retry_lim_q;
  logic [1:0] tries_q;
  logic [7:0] tmo_q;
  logic [15:0] err_q;
  logic [RIO_MAX_SLAVES-1:0] present_q;
  rio_type_t type_q [RIO_MAX_SLAVES];
  logic rsp_valid_q;
  rio_status_e rsp_status_q;
  rio_data_t rsp_data_q;

  logic rsp_match_c;
  logic abn_c;
  logic retry_c;
  logic done_c;
  rio_status_e done_st_c;
  logic last_slot_c;
  logic [1:0] next_slot_c;

  // only an answer from the addressed slave, sent to us, ends the wait
  assign rsp_match_c = link.rsp_valid && (link.rsp_src == dst_q) &&
                       (link.rsp_dst == RIO_MASTER_ADDR);
  // abnormality: no matching answer before the timeout expires
  assign abn_c = (state_q == RIO_WAIT) && !rsp_match_c && (tmo_q == RIO_TMO_LAST);
  assign retry_c = abn_c && (tries_q < retry_lim_q);
  assign last_slot_c = (slot_q == 2'(RIO_MAX_SLAVES - 1));
  assign next_slot_c = slot_q + 2'h1;

  always_comb begin
    done_c = 1'b0;
    done_st_c = RIO_ST_OK;
    if (state_q == RIO_SEND && !rio_addr_ok(dst_q)) begin
      done_c = 1'b1;
      done_st_c = RIO_ST_NO_SLAVE;
    end else if (state_q == RIO_WAIT && rsp_match_c) begin
      done_c = 1'b1;
      done_st_c = link.rsp_status;
    end else if (abn_c && !retry_c) begin
      done_c = 1'b1;
      done_st_c = RIO_ST_TIMEOUT;
    end
  end

  // transfer sequencer; an env setup walks all four slots, sending init requests only to slots with a valid address
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      state_q <= RIO_IDLE;
      slot_q <= 2'h0;
      dst_q <= RIO_MASTER_ADDR;
      cmd_q <= RIO_CMD_INIT;
      wdata_q <= 8'h00;
      init_run_q <= 1'b0;
      retry_lim_q <= RIO_RETRY_RST;
      tries_q <= 2'h0;
      tmo_q <= RIO_RSP_TIMEOUT_CYC;
    end else begin
      case (state_q)
        RIO_IDLE: begin
          tries_q <= 2'h0;
          if (env_set) begin
            retry_lim_q <= env_retry;
            init_run_q <= 1'b1;
            slot_q <= 2'h0;
            dst_q <= slot_addr[0];
            cmd_q <= RIO_CMD_INIT;
            state_q <= RIO_SEND;
          end else if (app_valid) begin
            slot_q <= app_slot;
            dst_q <= slot_addr[app_slot];
            cmd_q <= app_cmd;
            wdata_q <= app_wdata;
            state_q <= RIO_SEND;
          end
        end
        RIO_SEND: begin
          tmo_q <= RIO_RSP_TIMEOUT_CYC;
          if (rio_addr_ok(dst_q)) begin
            state_q <= RIO_WAIT;
          end
        end
        RIO_WAIT: begin
          if (retry_c) begin
            tries_q <= tries_q + 2'h1;
            state_q <= RIO_SEND;
          end else if (!done_c) begin
            tmo_q <= tmo_q - 8'h01;
          end
        end
        default: begin
          state_q <= RIO_IDLE;
        end
      endcase
      if (done_c) begin
        tries_q <= 2'h0;
        if (init_run_q && !last_slot_c) begin
          slot_q <= next_slot_c;
          dst_q <= slot_addr[next_slot_c];
          cmd_q <= RIO_CMD_INIT;
          state_q <= RIO_SEND;
        end else begin
          init_run_q <= 1'b0;
          state_q <= RIO_IDLE;
        end
      end
    end
  end

  // slave table is rebuilt by each env setup from the init answers
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      present_q <= '0;
      for (int i = 0; i < RIO_MAX_SLAVES; i++) begin
        type_q[i] <= 4'h0;
      end
    end else if (state_q == RIO_IDLE && env_set) begin
      present_q <= '0;
    end else if (done_c && init_run_q) begin
      present_q[slot_q] <= (done_st_c == RIO_ST_OK);
      type_q[slot_q] <= (done_st_c == RIO_ST_OK) ? link.rsp_data[3:0] : 4'h0;
    end
  end

  // app answers carry the slave's status unchanged, initial error included
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      rsp_valid_q <= 1'b0;
      rsp_status_q <= RIO_ST_OK;
      rsp_data_q <= 8'h00;
    end else begin
      rsp_valid_q <= done_c && !init_run_q;
      if (done_c && !init_run_q) begin
        rsp_status_q <= done_st_c;
        rsp_data_q <= rsp_match_c ? link.rsp_data : 8'h00;
      end
    end
  end

  // every detected abnormality counts until the total holds at ffff, so each retry adds one;
  // a count in the clear cycle survives as one rather than being lost
  always_ff @(posedge link.ref_clk) begin
    if (!link.rst_b) begin
      err_q <= RIO_ERR_RST;
    end else if (abn_c && err_clr) begin
      err_q <= RIO_ERR_ONE;
    end else if (abn_c && err_q != RIO_ERR_MAX) begin
      err_q <= err_q + RIO_ERR_ONE;
    end else if (err_clr) begin
      err_q <= RIO_ERR_RST;
    end
  end

  // request frame; source is always the master station
  assign link.req_valid = (state_q == RIO_SEND) && rio_addr_ok(dst_q);
  assign link.req_src = RIO_MASTER_ADDR;
  assign link.req_dst = dst_q;
  assign link.req_cmd = cmd_q;
  assign link.req_data = wdata_q;

  assign env_busy = init_run_q;
  assign app_ready = (state_q == RIO_IDLE) && !env_set;
  assign slot_present = present_q;
  assign slot_type = type_q;
  assign app_rsp_valid = rsp_valid_q;
  assign app_rsp_status = rsp_status_q;
  assign app_rsp_data = rsp_data_q;
  assign err_total = err_q;
endmodule // rio_master
`default_nettype wire

// file: tb/rio_link_monitor.sv
// link checker for the remote io master and slave pair
`timescale 1ns/10ps
`default_nettype none
module rio_link_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // request
  input wire logic req_valid,
  input wire rio_pkg::rio_addr_t req_src,
  input wire rio_pkg::rio_addr_t req_dst,
  input wire rio_pkg::rio_cmd_e req_cmd,
  // answer
  input wire logic rsp_valid,
  input wire rio_pkg::rio_addr_t rsp_src,
  input wire rio_pkg::rio_addr_t rsp_dst,
  input wire rio_pkg::rio_status_e rsp_status
);
  import rio_pkg::*;
  logic sent_init_q;
  logic init_ok_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // sent and answered are kept apart: a dropped init answer may still init
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      sent_init_q <= 1'b0;
    else if (req_valid && req_cmd == RIO_CMD_INIT)
      sent_init_q <= 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      init_ok_q <= 1'b0;
    else if (rsp_valid && rsp_status == RIO_ST_OK && $past(req_cmd) == RIO_CMD_INIT)
      init_ok_q <= 1'b1;
  end
  sequence s_lost;
    req_valid ##1 !rsp_valid;
  endsequence
  sequence s_init_rsp;
    rsp_valid && $past(req_cmd) == RIO_CMD_INIT;
  endsequence
  property p_src_zero;
    req_valid |-> req_src == RIO_MASTER_ADDR;
  endproperty
  property p_dst_range;
    req_valid |-> req_dst >= RIO_SLV_ADDR_MIN && req_dst <= RIO_SLV_ADDR_MAX;
  endproperty
  property p_gap;
    req_valid |=> !req_valid;
  endproperty
  property p_quiet;
    s_lost |=> !req_valid [*8];
  endproperty
  property p_pair;
    rsp_valid |-> $past(req_valid) && rsp_src == $past(req_dst) && rsp_dst == $past(req_src);
  endproperty
  property p_pre_init;
    rsp_valid && !sent_init_q && $past(req_cmd) != RIO_CMD_INIT
      |-> rsp_status == RIO_ST_INIT_ERR;
  endproperty
  property p_init_ok;
    s_init_rsp |-> rsp_status == RIO_ST_OK;
  endproperty
  property p_post_init;
    rsp_valid && init_ok_q |-> rsp_status == RIO_ST_OK;
  endproperty
  a_src_zero: assert property (p_src_zero) else $error("request not from station zero");
  a_dst_range: assert property (p_dst_range) else $error("request to bad station");
  a_gap: assert property (p_gap) else $error("requests back to back");
  a_quiet: assert property (p_quiet) else $error("resend before timeout");
  a_pair: assert property (p_pair) else $error("answer not paired");
  a_pre_init: assert property (p_pre_init) else $error("no initial error");
  a_init_ok: assert property (p_init_ok) else $error("init refused");
  a_post_init: assert property (p_post_init) else $error("refused after init");
endmodule // rio_link_monitor
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the remote io master and slave pair
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("Error at %0t: %h vs %h", $time, (a), (e)); \
  end \
end
module tb_top;
  import rio_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic env_set = 1'b0;
  logic [1:0] env_retry = 2'h0;
  rio_addr_t slot_addr [RIO_MAX_SLAVES] = '{4'h0, 4'h5, 4'h0, 4'h0};
  logic env_busy;
  logic [RIO_MAX_SLAVES-1:0] slot_present;
  rio_type_t slot_type [RIO_MAX_SLAVES];
  logic app_valid = 1'b0;
  logic app_ready;
  logic [1:0] app_slot = 2'h0;
  rio_cmd_e app_cmd = RIO_CMD_READ;
  rio_data_t app_wdata = 8'h00;
  logic app_rsp_valid;
  rio_status_e app_rsp_status;
  rio_data_t app_rsp_data;
  logic err_clr = 1'b0;
  logic [15:0] err_total;
  rio_data_t out_pins;
  logic drop_rsp = 1'b0;
  logic initialized;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  rio_link_if u_rio_link_if (.ref_clk(ref_clk), .rst_b(rst_b));
  rio_master u_rio_master (.link(u_rio_link_if), .env_set(env_set), .env_retry(env_retry),
    .slot_addr(slot_addr), .env_busy(env_busy), .slot_present(slot_present),
    .slot_type(slot_type), .app_valid(app_valid), .app_ready(app_ready),
    .app_slot(app_slot), .app_cmd(app_cmd), .app_wdata(app_wdata),
    .app_rsp_valid(app_rsp_valid), .app_rsp_status(app_rsp_status),
    .app_rsp_data(app_rsp_data), .err_clr(err_clr), .err_total(err_total));
  rio_slave u_rio_slave (.link(u_rio_link_if), .station_addr(4'h5), .unit_type(4'h9),
    .in_pins(8'h3c), .out_pins(out_pins), .drop_rsp(drop_rsp), .initialized(initialized));
  rio_link_monitor u_rio_link_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
    .req_valid(u_rio_link_if.req_valid), .req_src(u_rio_link_if.req_src),
    .req_dst(u_rio_link_if.req_dst), .req_cmd(u_rio_link_if.req_cmd),
    .rsp_valid(u_rio_link_if.rsp_valid), .rsp_src(u_rio_link_if.rsp_src),
    .rsp_dst(u_rio_link_if.rsp_dst), .rsp_status(u_rio_link_if.rsp_status));
  task automatic complete_run();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // bounded waits: a hung master shows as a mismatch, not a stall
  task automatic do_req(input logic [1:0] s, input rio_cmd_e c, input rio_data_t w,
      output rio_status_e st, output rio_data_t d);
    int n;
    n = 0;
    app_slot = s;
    app_cmd = c;
    app_wdata = w;
    app_valid = 1'b1;
    while (app_ready !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    tick();
    app_valid = 1'b0;
    while (app_rsp_valid !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    st = app_rsp_status;
    d = app_rsp_data;
    `CHK(n < 300, 1'b1)
  endtask
  task automatic t_env(input logic [1:0] lim);
    int n;
    n = 0;
    env_retry = lim;
    env_set = 1'b1;
    tick();
    env_set = 1'b0;
    `CHK(env_busy, 1'b1)
    `CHK(app_ready, 1'b0)
    while (env_busy === 1'b1 && n < 300) begin
      tick();
      n++;
    end
    `CHK(n < 300, 1'b1)
    `CHK(slot_present, 4'h2)
    `CHK(slot_type[1], 4'h9)
    `CHK(slot_type[0], 4'h0)
    `CHK(initialized, 1'b1)
  endtask
  task automatic t_clr();
    err_clr = 1'b1;
    tick();
    err_clr = 1'b0;
    `CHK(err_total, RIO_ERR_RST)
  endtask
  task automatic t_uninit();
    rio_status_e st;
    rio_data_t d;
    do_req(2'h1, RIO_CMD_WRITE, 8'h5a, st, d);
    `CHK(st, RIO_ST_INIT_ERR)
    `CHK(out_pins, RIO_OUT_RST)
  endtask
  task automatic t_rw();
    rio_status_e st;
    rio_data_t d;
    do_req(2'h1, RIO_CMD_WRITE, 8'ha5, st, d);
    `CHK(st, RIO_ST_OK)
    `CHK(out_pins, 8'ha5)
    do_req(2'h1, RIO_CMD_READ, 8'h00, st, d);
    `CHK(d, 8'h3c)
    do_req(2'h0, RIO_CMD_READ, 8'h00, st, d);
    `CHK(st, RIO_ST_NO_SLAVE)
    `CHK(err_total, RIO_ERR_RST)
  endtask
  // every attempt times out, so the total equals the attempts made
  task automatic t_retry();
    rio_status_e st;
    rio_data_t d;
    for (int i = 0; i < 4; i++) begin
      t_clr();
      t_env(2'(i));
      drop_rsp = 1'b1;
      do_req(2'h1, RIO_CMD_READ, 8'h00, st, d);
      tick();
      drop_rsp = 1'b0;
      `CHK(st, RIO_ST_TIMEOUT)
      `CHK(err_total, 16'(i + 1))
    end
  endtask
  task automatic t_recover();
    rio_status_e st;
    rio_data_t d;
    t_clr();
    t_env(2'h1);
    drop_rsp = 1'b1;
    fork
      do_req(2'h1, RIO_CMD_READ, 8'h00, st, d);
      begin
        repeat (10) tick();
        drop_rsp = 1'b0;
      end
    join
    `CHK(st, RIO_ST_OK)
    `CHK(err_total, RIO_ERR_ONE)
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) tick();
    rst_b = 1'b1;
    `CHK(err_total, RIO_ERR_RST)
    t_uninit();
    t_env(2'h2);
    t_rw();
    t_retry();
    t_recover();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
